// ==== core/lcg_map.vh ====
`ifndef LCG_MAP_VH
`define LCG_MAP_VH
// ****************************************
// register map
// ****************************************
`define LCG_SEL_ADDR      12'h000
`define LCG_IN_ADDR       12'h004
`define LCG_GATE_ADDR     12'h008
`define LCG_SEL_RESET     8'h00
`define LCG_BIT_IN1_INV   0
`define LCG_BIT_IN1_TRUE  1
`define LCG_BIT_IN2_INV   2
`define LCG_BIT_IN2_TRUE  3
`define LCG_BIT_IN3_INV   4
`define LCG_BIT_IN3_TRUE  5
`define LCG_BIT_IN4_INV   6
`define LCG_BIT_IN4_TRUE  7
`define LCG_HTRANS_NONSEQ 2'h2
`define LCG_HSIZE_WORD    3'h2
`define LCG_SEL_W         8
`define LCG_DATA_W        4
`define LCG_BUS_W         32
`define LCG_ADDR_W        12
`define LCG_IDX_NONE      2'h0
`define LCG_IDX_SEL       2'h1
`define LCG_IDX_IN        2'h2
`define LCG_IDX_GATE      2'h3
`define LCG_BITS_PER_IN   2
`define LCG_OFS_TRUE      1
`define LCG_OFS_INV       0
`define LCG_RDATA_RESET   32'h00000000
`define LCG_RDATA_UNMAP   32'h00000000
`define LCG_GATE_RESET    8'h00
`define LCG_READY_ON      1'b1
`define LCG_HRESP_OKAY    1'b0
`endif

// ==== core/lcg_sync.v ====
`timescale 1ns/1ps
// ****************************************
// two-stage synchroniser, one per bit
// ****************************************
module lcg_sync #(
	parameter WIDTH = 4
) (
	hclk,
	hresetn,
	async_in,
	sync_out
);
	input  wire             hclk;
	input  wire             hresetn;
	input  wire [WIDTH-1:0] async_in;
	output wire [WIDTH-1:0] sync_out;

	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;

	// the first stage feeds only the second stage
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_ff <= {WIDTH{1'b0}};
			sync_ff <= {WIDTH{1'b0}};
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule

// ==== core/lcg_gate0_select.v ====
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "lcg_map.vh"
module lcg_gate0_select (
	hclk,
	hresetn,
	hsel,
	haddr,
	htrans,
	hwrite,
	hsize,
	hready,
	hwdata,
	hrdata,
	hreadyout,
	hresp,
	logic_data_in_a,
	logic_data_in_b,
	logic_data_in_c,
	logic_data_in_d,
	gate0_sel
);
	input  wire        hclk;
	input  wire        hresetn;
	input  wire        hsel;
	input  wire [11:0] haddr;
	input  wire [1:0]  htrans;
	input  wire        hwrite;
	input  wire [2:0]  hsize;
	input  wire        hready;
	input  wire [31:0] hwdata;
	output reg  [31:0] hrdata;
	output reg         hreadyout;
	output reg         hresp;
	input  wire        logic_data_in_a;
	input  wire        logic_data_in_b;
	input  wire        logic_data_in_c;
	input  wire        logic_data_in_d;
	output reg  [7:0]  gate0_sel;

	// ****************************************
	// input synchronisers
	// ****************************************
	wire [`LCG_DATA_W-1:0] data_raw;
	wire [`LCG_DATA_W-1:0] data_sync;

	assign data_raw = {logic_data_in_d, logic_data_in_c, logic_data_in_b, logic_data_in_a};

	lcg_sync #(
		.WIDTH (`LCG_DATA_W)
	) u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in (data_raw),
		.sync_out (data_sync)
	);

	// ****************************************
	// local sizes
	// ****************************************
	// the port widths are fixed by the pins, so these stay local
	localparam BUS_W    = `LCG_BUS_W;
	localparam ADDR_W   = `LCG_ADDR_W;
	localparam SEL_W    = `LCG_SEL_W;
	localparam DATA_W   = `LCG_DATA_W;
	localparam SEL_PAD  = BUS_W - SEL_W;
	localparam DATA_PAD = BUS_W - DATA_W;

	// ****************************************
	// helper functions
	// ****************************************
	// the write strobe and the read mux share one decode so they cannot drift apart
	function [1:0] reg_index;
		input [ADDR_W-1:0] addr;
		begin
			case (addr)
				`LCG_SEL_ADDR:  reg_index = `LCG_IDX_SEL;
				`LCG_IN_ADDR:   reg_index = `LCG_IDX_IN;
				`LCG_GATE_ADDR: reg_index = `LCG_IDX_GATE;
				default:        reg_index = `LCG_IDX_NONE;
			endcase
		end
	endfunction

	// one form of one input: the enable gates the plain or the inverted level
	function form_pass;
		input en;
		input level;
		input invert;
		begin
			form_pass = en & (level ^ invert);
		end
	endfunction

	// ****************************************
	// ahb-lite address phase
	// ****************************************
	reg  [SEL_W-1:0] sel_ff;
	reg  [SEL_W-1:0] nxt_sel;
	reg              wr_pend_ff;
	reg  [1:0]       wr_idx_ff;
	reg  [SEL_W-1:0] gate_ff;
	reg  [BUS_W-1:0] nxt_rdata;
	wire [SEL_W-1:0] nxt_gate;
	wire             xfer;
	wire             xfer_wr;
	wire             xfer_rd;
	wire [1:0]       addr_idx;

	// only nonseq single transfers are taken; hsize is not checked, whole words only
	assign xfer     = hsel && hready && (htrans == `LCG_HTRANS_NONSEQ);
	assign xfer_wr  = xfer && hwrite;
	assign xfer_rd  = xfer && !hwrite;
	assign addr_idx = reg_index(haddr);

	// only the decoded index is kept for the data phase, not the whole address
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff  <= `LCG_IDX_NONE;
		end else begin
			wr_pend_ff <= xfer_wr;
			if (xfer)
				wr_idx_ff <= addr_idx;
		end
	end

	// ****************************************
	// select register
	// ****************************************
	// the read mux looks at nxt_sel, so a read issued in the data phase
	// of a write already returns the new value
	always @* begin
		nxt_sel = sel_ff;
		if (wr_pend_ff && (wr_idx_ff == `LCG_IDX_SEL))
			nxt_sel = hwdata[SEL_W-1:0];
	end

	// contents are undefined after power-on; zero is one legal choice
	// a write to any other offset leaves the register alone
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_ff <= `LCG_SEL_RESET;
		end else begin
			sel_ff <= nxt_sel;
		end
	end

	// ****************************************
	// read data
	// ****************************************
	// unmapped offsets read as zero
	always @* begin
		case (addr_idx)
			`LCG_IDX_SEL:  nxt_rdata = {{SEL_PAD{1'b0}}, nxt_sel};
			`LCG_IDX_IN:   nxt_rdata = {{DATA_PAD{1'b0}}, data_sync};
			`LCG_IDX_GATE: nxt_rdata = {{SEL_PAD{1'b0}}, gate_ff};
			default:       nxt_rdata = `LCG_RDATA_UNMAP;
		endcase
	end

	// read data is loaded at the address phase and then stands through the data
	// phase and beyond, until the next read is taken
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= `LCG_RDATA_RESET;
		end else begin
			if (xfer_rd)
				hrdata <= nxt_rdata;
		end
	end

	// ****************************************
	// response
	// ****************************************
	// no wait states and no error path: every transfer, mapped or not, ends okay
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= `LCG_READY_ON;
			hresp     <= `LCG_HRESP_OKAY;
		end else begin
			hreadyout <= `LCG_READY_ON;
			hresp     <= `LCG_HRESP_OKAY;
		end
	end

	// ****************************************
	// gate 0 input steering
	// ****************************************
	// input gi owns a bit pair: the upper bit its true form, the lower its inverted form
	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_steer
			localparam TRUE_BIT = gi * `LCG_BITS_PER_IN + `LCG_OFS_TRUE;
			localparam INV_BIT  = gi * `LCG_BITS_PER_IN + `LCG_OFS_INV;

			assign nxt_gate[TRUE_BIT] = form_pass(sel_ff[TRUE_BIT], data_sync[gi], 1'b0);
			assign nxt_gate[INV_BIT]  = form_pass(sel_ff[INV_BIT], data_sync[gi], 1'b1);
		end
	endgenerate

	// ****************************************
	// gate 0 outputs
	// ****************************************
	// a deselected form drives zero so an or-type gate ignores it; gate_ff is the
	// copy the bus reads, so the output pins carry no load from the read mux
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gate_ff   <= `LCG_GATE_RESET;
			gate0_sel <= `LCG_GATE_RESET;
		end else begin
			gate_ff   <= nxt_gate;
			gate0_sel <= nxt_gate;
		end
	end
endmodule

// ==== sim/lcg_gate0_select_sva.sv ====
`timescale 1ns/1ps
`include "lcg_map.vh"
// ****************************************
// gate 0 select checks
// ****************************************
module lcg_gate0_select_sva (
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [11:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire [31:0] hwdata,
	input wire        logic_data_in_a,
	input wire        logic_data_in_b,
	input wire        logic_data_in_c,
	input wire        logic_data_in_d,
	input wire [7:0]  gate0_sel
);
	// shadow of the select register, rebuilt from the bus; unknown until first written
	reg       shd_pend_ff;
	reg [7:0] shd_sel_ff;
	reg       shd_ok_ff;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shd_pend_ff <= 1'b0;
			shd_sel_ff  <= `LCG_SEL_RESET;
			shd_ok_ff   <= 1'b0;
		end else begin
			shd_pend_ff <= hsel && hready && (htrans == `LCG_HTRANS_NONSEQ) && hwrite && (haddr == `LCG_SEL_ADDR);
			if (shd_pend_ff) begin
				shd_sel_ff <= hwdata[7:0];
				shd_ok_ff  <= 1'b1;
			end
		end
	end

	// two synchroniser edges plus the output register: three edges in all
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_in4_true: assert property (gate0_sel[7] |-> $past(logic_data_in_d, 3)) else $error("in4 true");
	a_in4_inv: assert property (gate0_sel[6] |-> !$past(logic_data_in_d, 3)) else $error("in4 inv");
	a_in3_true: assert property (gate0_sel[5] |-> $past(logic_data_in_c, 3)) else $error("in3 true");
	a_in3_inv: assert property (gate0_sel[4] |-> !$past(logic_data_in_c, 3)) else $error("in3 inv");
	a_in2_true: assert property (gate0_sel[3] |-> $past(logic_data_in_b, 3)) else $error("in2 true");
	a_in2_inv: assert property (gate0_sel[2] |-> !$past(logic_data_in_b, 3)) else $error("in2 inv");
	a_in1_true: assert property (gate0_sel[1] |-> $past(logic_data_in_a, 3)) else $error("in1 true");
	a_in1_inv: assert property (gate0_sel[0] |-> !$past(logic_data_in_a, 3)) else $error("in1 inv");

	// enabled forms pass, disabled forms are held low, per the written select value
	property p_gate_model;
		$past(shd_ok_ff, 1) |->
			gate0_sel == ($past(shd_sel_ff, 1) & {$past(logic_data_in_d, 3), !$past(logic_data_in_d, 3),
			$past(logic_data_in_c, 3), !$past(logic_data_in_c, 3), $past(logic_data_in_b, 3),
			!$past(logic_data_in_b, 3), $past(logic_data_in_a, 3), !$past(logic_data_in_a, 3)});
	endproperty
	a_gate_model: assert property (p_gate_model) else $error("gate 0 select differs from model");
endmodule
bind lcg_gate0_select lcg_gate0_select_sva u_sva (.hclk(hclk), .hresetn(hresetn), .gate0_sel(gate0_sel),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
	.logic_data_in_a(logic_data_in_a), .logic_data_in_b(logic_data_in_b),
	.logic_data_in_c(logic_data_in_c), .logic_data_in_d(logic_data_in_d));

// ==== sim/tb_lcg_gate0_select.sv ====
`timescale 1ns/1ps
`include "lcg_map.vh"
module tb_lcg_gate0_select;
	reg         hclk = 0;
	reg         hresetn = 0;
	reg  [11:0] haddr = 0;
	reg  [1:0]  htrans = 0;
	reg         hwrite = 0;
	reg  [31:0] hwdata = 0;
	reg  [3:0]  din = 0;
	wire [31:0] hrdata;
	wire        hreadyout;
	wire        hresp;
	wire [7:0]  gate0_sel;
	reg  [31:0] r;
	reg  [31:0] e;
	reg  [31:0] rnd;
	reg  [31:0] exp_q[$];
	integer     model_sel;
	integer     error_cnt = 0;
	integer     num_checks = 0;
	integer     i;
	always #10 hclk = ~hclk;
	lcg_gate0_select DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(`LCG_HSIZE_WORD), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .logic_data_in_a(din[0]), .logic_data_in_b(din[1]),
		.logic_data_in_c(din[2]), .logic_data_in_d(din[3]), .gate0_sel(gate0_sel));
	// ****************************************
	// bus tasks
	// ****************************************
	task xfer(input [11:0] a, input w, input [31:0] d, output [31:0] q);
		htrans <= `LCG_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	// reference model: an enabled form passes its level, a disabled one is held low
	function [31:0] model_gate(input integer s, input [3:0] d);
		integer k;
		begin
			model_gate = 32'h0;
			for (k = 0; k < 4; k = k + 1) begin
				model_gate[2 * k + 1] = s[2 * k + 1] && d[k];
				model_gate[2 * k]     = s[2 * k] && !d[k];
			end
		end
	endfunction
	task chk(input [31:0] s, input [31:0] x);
		num_checks = num_checks + 1;
		if (s !== x) begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %0t seen %h expected %h", $time, s, x);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt = error_cnt + 1;
		final_report;
	end
	initial begin
		void'($urandom(32'h9F2B7663));
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (i = 0; i < 40; i = i + 1) begin
			// upper write bits stay random so a leak above bit 7 shows on readback
			e = $urandom;
			rnd = $urandom;
			din <= rnd[3:0];
			xfer(`LCG_SEL_ADDR, 1'b1, e, r);
			model_sel = e[7:0];
			// a write to an unmapped offset must leave the select register alone
			xfer(12'h00C, 1'b1, ~e, r);
			exp_q.push_back(model_sel);
			exp_q.push_back(rnd[3:0]);
			exp_q.push_back(model_gate(model_sel, rnd[3:0]));
			exp_q.push_back(32'h0);
			xfer(`LCG_SEL_ADDR, 1'b0, 32'h0, r);
			chk(r, exp_q.pop_front());
			xfer(`LCG_IN_ADDR, 1'b0, 32'h0, r);
			chk(r, exp_q.pop_front());
			xfer(`LCG_GATE_ADDR, 1'b0, 32'h0, r);
			e = exp_q.pop_front();
			chk(r, e);
			chk({24'h0, gate0_sel}, e);
			xfer(12'h00C, 1'b0, 32'h0, r);
			chk(r, exp_q.pop_front());
		end
		final_report;
	end
endmodule
